//--- include/ptu_regs.vh
// Register offsets, field positions, reset values and counts of the periodic tick unit.
// Assumes an APB slave with 32-bit data, one register per aligned word.
// Function
// - Counter held at zero while run is low; setting run restarts counting from zero.
// - Fifteen divider stages, eight of them selectable as event tap.
// - Overflow at selected tap sets the flag; direct writes cannot set or clear it.
// - Flag with interrupt enable set raises a CPU request; with it disabled the status bank and its own enable can still raise one.
// - Flag clear bit is write-only, reads zero; one clears flag, zero ignored.
// - First event comes after about half a period, later ones exactly one period.
// - Rate select codes 0..7 divide by 32768,8192,2048,128,64,32,16,8.
// - Reset clears run and interrupt enable; counter zero, interrupt masked.
// - In wait mode counting continues; control register not reachable by CPU.
// - In stop mode unit runs only when oscillator is kept alive in stop.
// - Without oscillator in stop the unit is idle; register unreachable in stop.
// - Counter advances on crystal reference clock, meant to be 32.768 kHz.
`ifndef PTU_REGS_VH
`define PTU_REGS_VH

// Byte offsets
`define PTU_CTRL_OFF     12'h000
`define PTU_IRQ_STAT_OFF 12'h004
`define PTU_IRQ_EN_OFF   12'h008
`define PTU_IRQ_CLR_OFF  12'h00c

// Control register fields
`define PTU_F_FLAG       7
`define PTU_F_RATE_HI    6
`define PTU_F_RATE_LO    4
`define PTU_F_CLEAR      3
`define PTU_F_IEN        2
`define PTU_F_RUN        1

// Reset values and counter size
`define PTU_CTRL_RST     8'h00
`define PTU_DIV_STAGES   15

`endif

//--- src/ptu_sync.v
// Three-stage synchroniser with agreement filter for one pin-level input.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/1ps
module ptu_sync (
  input  wire pclk,     // System clock
  input  wire presetn,  // Async reset, active low
  input  wire din,      // Asynchronous input
  output reg  dout      // Filtered level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Stage one feeds only stage two; change counts once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule // ptu_sync

//--- src/ptu_top.v
// Periodic tick unit: crystal divider, tap select, tick flag and APB registers.
// Assumes the crystal reference and low-power mode levels arrive asynchronously on pins.
`timescale 1ns/1ps
`include "ptu_regs.vh"
module ptu_top (
  input  wire        pclk,              // APB clock, 100 MHz
  input  wire        presetn,           // Async reset, active low
  input  wire        psel,              // APB select
  input  wire        penable,           // APB access phase
  input  wire        pwrite,            // APB direction
  input  wire [11:0] paddr,             // APB byte address
  input  wire [31:0] pwdata,            // APB write data
  output reg  [31:0] prdata,            // APB read data
  output reg         pready,            // APB ready
  output reg         pslverr,           // APB error
  input  wire        crystal_ref_clock, // Crystal reference, sampled
  input  wire        wait_mode,         // CPU in wait mode
  input  wire        stop_mode,         // CPU in stop mode
  input  wire        osc_keep_in_stop,  // Oscillator kept alive in stop
  output reg         tick_irq           // Level interrupt request
);
  wire                       xtal_s;
  wire                       wait_s;
  wire                       stop_s;
  wire                       osc_s;
  reg                        xtal_d_r;
  reg  [`PTU_DIV_STAGES-1:0] div_r;
  reg  [`PTU_DIV_STAGES-1:0] div_nxt;
  reg                        tick_run_r;
  reg                        tick_irq_enable_r;
  reg  [2:0]                 tick_rate_select_r;
  reg                        tick_flag_r;
  reg                        ov_stat_r;
  reg                        ov_en_r;
  reg  [3:0]                 tap_idx;
  wire                       xtal_rise;
  wire                       counting;
  wire                       tick_evt;
  wire                       setup;
  wire                       access;
  wire                       wr_ok;
  wire                       bus_blocked;
  wire [7:0]                 ctrl_rd;

  // Pins cross into pclk through three-stage filters
  ptu_sync u_sx (.pclk(pclk), .presetn(presetn), .din(crystal_ref_clock), .dout(xtal_s));
  ptu_sync u_sw (.pclk(pclk), .presetn(presetn), .din(wait_mode),         .dout(wait_s));
  ptu_sync u_ss (.pclk(pclk), .presetn(presetn), .din(stop_mode),         .dout(stop_s));
  ptu_sync u_so (.pclk(pclk), .presetn(presetn), .din(osc_keep_in_stop),  .dout(osc_s));

  // Crystal edge acts as the counter's enable pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_d_r <= 1'b0;
    end else begin
      xtal_d_r <= xtal_s;
    end
  end
  assign xtal_rise = xtal_s & ~xtal_d_r;

  // Stop freezes the counter unless the oscillator is kept alive; wait does not
  assign counting = tick_run_r & xtal_rise & (~stop_s | osc_s);

  // Tap index per rate code: divider 2^(idx+1)
  always @* begin
    case (tick_rate_select_r)
      3'h0:    tap_idx = 4'he;
      3'h1:    tap_idx = 4'hc;
      3'h2:    tap_idx = 4'ha;
      3'h3:    tap_idx = 4'h6;
      3'h4:    tap_idx = 4'h5;
      3'h5:    tap_idx = 4'h4;
      3'h6:    tap_idx = 4'h3;
      default: tap_idx = 4'h2;
    endcase
  end

  // Event when the selected tap bit rises: first after half a period
  assign tick_evt = counting & ~div_r[tap_idx] & div_nxt[tap_idx];

  // Divider chain, cleared while run is low
  always @* begin
    div_nxt = div_r + {{(`PTU_DIV_STAGES-1){1'b0}}, 1'b1};
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= {`PTU_DIV_STAGES{1'b0}};
    end else if (!tick_run_r) begin
      div_r <= {`PTU_DIV_STAGES{1'b0}};
    end else if (counting) begin
      div_r <= div_nxt;
    end
  end

  // Bus decode; CPU cannot reach the registers in wait or stop
  assign setup       = psel & ~penable;
  assign access      = psel & penable & pready;
  assign bus_blocked = wait_s | stop_s;
  assign wr_ok       = access & pwrite & ~bus_blocked;

  // Control fields; rate writes while running are accepted, software avoids them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_run_r         <= 1'b0;
      tick_irq_enable_r  <= 1'b0;
      tick_rate_select_r <= 3'h0;
    end else if (wr_ok && paddr == `PTU_CTRL_OFF) begin
      tick_run_r         <= pwdata[`PTU_F_RUN];
      tick_irq_enable_r  <= pwdata[`PTU_F_IEN];
      tick_rate_select_r <= pwdata[`PTU_F_RATE_HI:`PTU_F_RATE_LO];
    end
  end

  // Tick flag: set by event, cleared only by writing one to the clear bit; set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_flag_r <= 1'b0;
    end else if (tick_evt) begin
      tick_flag_r <= 1'b1;
    end else if (wr_ok && paddr == `PTU_CTRL_OFF && pwdata[`PTU_F_CLEAR]) begin
      tick_flag_r <= 1'b0;
    end
  end

  // Sticky status of tick events, separate enable, write-one-to-clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_stat_r <= 1'b0;
      ov_en_r   <= 1'b0;
    end else begin
      if (tick_evt) begin
        ov_stat_r <= 1'b1;
      end else if (wr_ok && paddr == `PTU_IRQ_CLR_OFF && pwdata[0]) begin
        ov_stat_r <= 1'b0;
      end
      if (wr_ok && paddr == `PTU_IRQ_EN_OFF) begin
        ov_en_r <= pwdata[0];
      end
    end
  end

  // Level request from flag with its enable, or the status bank
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_irq <= 1'b0;
    end else begin
      tick_irq <= (tick_flag_r & tick_irq_enable_r) | (ov_stat_r & ov_en_r);
    end
  end

  // Control read image: clear bit and bit 0 read zero
  assign ctrl_rd = {tick_flag_r, tick_rate_select_r, 1'b0,
                    tick_irq_enable_r, tick_run_r, 1'b0};

  // APB: no wait state, ready the cycle after setup, reads registered, unmapped or blocked gives error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (bus_blocked) begin
        pslverr <= 1'b1;
      end else if (paddr == `PTU_CTRL_OFF) begin
        prdata <= {24'h00_0000, ctrl_rd};
      end else if (paddr == `PTU_IRQ_STAT_OFF) begin
        prdata <= {31'h0000_0000, ov_stat_r};
      end else if (paddr == `PTU_IRQ_EN_OFF) begin
        prdata <= {31'h0000_0000, ov_en_r};
      end else if (paddr == `PTU_IRQ_CLR_OFF) begin
        prdata <= 32'h0000_0000;
      end else begin
        pslverr <= 1'b1;
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // ptu_top

//--- verification/ptu_top_asserts.sv
// Checker for the tick unit's bus answer and interrupt level.
// Assumes it is bound onto ptu_top and sees only its ports.
`timescale 1ns/1ps
module ptu_top_asserts (
  input wire        pclk,             // clock
  input wire        presetn,          // reset, low
  input wire        psel,             // select
  input wire        penable,          // access
  input wire        pwrite,           // direction
  input wire [11:0] paddr,            // address
  input wire [31:0] prdata,           // read data
  input wire        pready,           // ready
  input wire        pslverr,          // error
  input wire        wait_mode,        // wait level
  input wire        stop_mode,        // stop level
  input wire        osc_keep_in_stop, // osc in stop
  input wire        tick_irq          // interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed access, the only point where data counts
  wire acc = psel && penable && pready;
  ack_timing_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  unmapped_err_a: assert property (acc && paddr > 12'h00c |-> pslverr)
    else $error("unmapped access not refused");
  ctrl_zeros_a: assert property (acc && !pwrite && paddr == 12'h000 && !pslverr
    |-> prdata[31:8] == 24'h0 && !prdata[3] && !prdata[0])
    else $error("control read shows nonzero fixed bits");
  // Sync lag is about four cycles, so six give margin
  wait_refuse_a: assert property (wait_mode[*6] ##0 acc |-> pslverr)
    else $error("bus answered in wait mode");
  stop_quiet_a: assert property ((stop_mode && !osc_keep_in_stop)[*8]
    |-> !$rose(tick_irq))
    else $error("event while stopped");
  irq_level_a: assert property ($fell(tick_irq)
    |-> $past(acc && pwrite) || $past(acc && pwrite, 2))
    else $error("interrupt dropped without a write");
  reset_quiet_a: assert property (!$past(presetn) |-> !tick_irq && !pready)
    else $error("output active after reset");
  cover property (acc && pslverr);
  cover property ($rose(tick_irq));
  cover property ($fell(tick_irq));
endmodule // ptu_top_asserts

bind ptu_top ptu_top_asserts u_chk (.*);

//--- verification/ptu_tb_top.sv
// Bench for the tick unit: APB master, free crystal source, read scoreboard.
// Assumes control at 0x000, irq status, enable, clear at 0x004..0x00c.
`timescale 1ns/1ps
module ptu_tb_top;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0, r;
  reg         crystal_ref_clock = 0, wait_mode = 0, stop_mode = 0, osc_keep_in_stop = 0;
  wire [31:0] prdata;
  wire        pready, pslverr, tick_irq;
  reg  [32:0] expq[$];
  integer     n_mismatch = 0, comparisons = 0, edges = 0, cyc = 0, k, h, i;

  ptu_top dut (.*);

  always #5 pclk = ~pclk;
  // Crystal at 1/16 of pclk, slow enough for the sync chain; also the timeout
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 7) begin
      crystal_ref_clock <= ~crystal_ref_clock;
      if (!crystal_ref_clock) edges <= edges + 1;
    end
    if (cyc == 40000) begin
      n_mismatch++;
      stop_test;
    end
  end

  task cmp(input string nm, input [32:0] e, input [32:0] s);
    begin
      comparisons++;
      if (s !== e) begin
        n_mismatch++;
        $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
    end
  endtask

  // Read results checked as they appear, against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) cmp("read", expq.pop_front(), {pslverr, prdata});

  task xfer(input w, input [11:0] a, input [31:0] d, input [32:0] e);
    integer t;
    begin
      if (!w) expq.push_back(e);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      t = 0;
      do @(posedge pclk); while (!pready && ++t < 20);
      if (!pready) n_mismatch++;
      psel <= 0; penable <= 0;
      @(posedge pclk);
    end
  endtask

  task wirq(input v);
    integer t;
    begin
      t = 0;
      while (tick_irq !== v && t < 3000) begin
        @(posedge pclk);
        t++;
      end
      cmp("irq", v, tick_irq);
    end
  endtask

  task stop_test;
    begin
      if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  initial begin
    k = $urandom(97593);
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    xfer(0, 12'h000, 0, 33'h0);
    // Every rate code, with flag, clear and reserved bits written as 1
    for (i = 0; i < 8; i++) begin
      r = $urandom;
      r[7:0] = {1'b1, i[2:0], 4'hd};
      xfer(1, 12'h000, r, 0);
      xfer(0, 12'h000, 0, {25'h0, i[2:0], 4'h4});
    end
    // Stop before each rate change; first event near half, then full period
    for (i = 7; i >= 3; i--) begin
      h = 4 << (7 - i);
      xfer(1, 12'h000, 32'h08, 0);
      xfer(1, 12'h000, {25'h0, i[2:0], 4'he}, 0);
      k = edges;
      wirq(1);
      cmp("first", 1, edges - k >= h - 2 && edges - k <= h + 2);
      xfer(1, 12'h000, {25'h0, i[2:0], 4'he}, 0);
      k = edges;
      wirq(0);
      wirq(1);
      cmp("period", 2 * h, edges - k);
    end
    xfer(1, 12'h000, 32'h08, 0);
    xfer(1, 12'h000, 32'h7e, 0);
    stop_mode <= 1;
    repeat (300) @(posedge pclk);
    cmp("irq", 0, tick_irq);
    osc_keep_in_stop <= 1;
    wirq(1);
    stop_mode <= 0;
    osc_keep_in_stop <= 0;
    // Let the synchronised stop level fall before the bus is used again
    repeat (6) @(posedge pclk);
    // Sticky status path: raise, read, mask, clear
    xfer(1, 12'h000, 0, 0);
    wirq(0);
    xfer(1, 12'h008, 1, 0);
    wirq(1);
    xfer(0, 12'h004, 0, 33'h1);
    xfer(1, 12'h008, 0, 0);
    wirq(0);
    xfer(1, 12'h008, 1, 0);
    xfer(1, 12'h00c, 1, 0);
    wirq(0);
    xfer(0, 12'h004, 0, 33'h0);
    // Bus refused in wait; run and flag survive it
    xfer(1, 12'h000, 32'h02, 0);
    wait_mode <= 1;
    repeat (6) @(posedge pclk);
    xfer(1, 12'h000, 0, 0);
    xfer(0, 12'h000, 0, 33'h100000000);
    wait_mode <= 0;
    repeat (6) @(posedge pclk);
    xfer(0, 12'h000, 0, 33'h82);
    xfer(1, 12'h010, 0, 0);
    xfer(0, 12'h010, 0, 33'h100000000);
    stop_test;
  end
endmodule // ptu_tb_top
